// [core/eda_ctrl.sv]
// Functional notes
// - 64 data bytes at addresses 00h..3Fh, readable and writable in use.
// - cpu reaches array only through address, data, control and unlock registers.
// - a byte write first erases the location, then programs the new byte.
// - write duration is timed by an internal counter, not software.
// - under code protection cpu keeps access; programmer port is refused.
// - address upper two bits decode; nonzero selects no location.
// - control bits 7..5 are absent and read zero.
// - done flag bit 4 set at write end; software or a warm reset clears it.
// - abort flag bit 3 set when master clear or watchdog cuts a write.
// - address and data registers keep contents across an aborting reset.
// - permit bit 2 allows writes when set; cleared at power-up.
// - program-start bit 1 set-only by software, cleared by hardware at end.
// - fetch-start bit 0 set-only; read takes one cycle, then clears.
// - unlock register has no storage and reads zero.
// - write starts only after 55h, AAh to unlock, then setting bit 1.
// - fetched byte lands in data register next cycle and stays there.
// - start bit cannot set without permit; later permit clear harmless.
`timescale 1ns/10ps
module eda_ctrl
    import eda_pkg::*;
#(
    parameter int ERASE_CYCLES = EDA_ERASE_CYC,
    parameter int PROG_CYCLES = EDA_PROG_CYC
) (
    // clock and power-on reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // warm resets from the core, same clock
    input wire logic master_clear_reset,
    input wire logic watchdog_timeout,
    // special function register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // programmer side access
    input wire logic code_protect,
    input wire logic prog_rd_en,
    input wire logic prog_wr_en,
    input wire logic [5:0] prog_addr,
    input wire logic [7:0] prog_wdata,
    output logic [7:0] prog_rdata_ff,
    output logic prog_denied_ff
);

    // ************************************************************
    // state
    // ************************************************************
    logic [7:0] mem [EDA_DEPTH];
    logic [7:0] data_ff;
    logic [7:0] addr_ff;
    logic fetch_ff;
    logic start_ff;
    logic permit_ff;
    logic abort_ff;
    logic done_ff;
    eda_unlock_e ul_ff;
    eda_wstate_e ws_ff;
    logic [15:0] cnt_ff;
    logic [5:0] wloc_ff;
    logic [7:0] wbyte_ff;

    logic warm_rst;
    logic addr_hit;
    logic [7:0] rd_word;
    logic wr_ctrl;
    logic wr_unlock;
    logic start_ok;
    logic wr_end;
    logic erase_end;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    assign warm_rst = master_clear_reset | watchdog_timeout;
    // bus writes during a warm reset are ignored
    assign wr_ctrl = sfr_wr && !warm_rst && sfr_addr == EDA_ADR_CTRL;
    assign wr_unlock = sfr_wr && !warm_rst && sfr_addr == EDA_ADR_UNLOCK;
    assign addr_hit = addr_ff[7:6] == 2'b00;
    assign rd_word = addr_hit ? mem[addr_ff[5:0]] : EDA_RST_BYTE;
    assign start_ok = wr_ctrl && sfr_wdata[EDA_BIT_PROG] && permit_ff
        && ul_ff == EDA_UL_ARMED && ws_ff == EDA_WS_IDLE;
    assign erase_end = ws_ff == EDA_WS_ERASE && cnt_ff == 16'h0000;
    assign wr_end = ws_ff == EDA_WS_PROG && cnt_ff == 16'h0000 && !warm_rst;

    // ************************************************************
    // register read mux
    // ************************************************************
    always_comb begin
        unique case (sfr_addr)
            EDA_ADR_DATA: sfr_rdata = data_ff;
            EDA_ADR_ADDR: sfr_rdata = addr_ff;
            EDA_ADR_CTRL: sfr_rdata = {3'b000, done_ff, abort_ff,
                permit_ff, start_ff, fetch_ff};
            EDA_ADR_UNLOCK: sfr_rdata = 8'h00;
            default: sfr_rdata = 8'h00;
        endcase
    end

    // ************************************************************
    // address and data registers
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            addr_ff <= EDA_RST_BYTE;
        end else if (sfr_wr && !warm_rst && sfr_addr == EDA_ADR_ADDR) begin
            addr_ff <= sfr_wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            data_ff <= EDA_RST_BYTE;
        end else if (fetch_ff) begin
            data_ff <= rd_word;
        end else if (sfr_wr && !warm_rst && sfr_addr == EDA_ADR_DATA) begin
            data_ff <= sfr_wdata;
        end
    end

    // ************************************************************
    // control bits
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_n || warm_rst) begin
            fetch_ff <= 1'b0;
        end else if (fetch_ff) begin
            fetch_ff <= 1'b0;
        end else if (wr_ctrl && sfr_wdata[EDA_BIT_FETCH]) begin
            fetch_ff <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n || warm_rst) begin
            permit_ff <= 1'b0;
        end else if (wr_ctrl) begin
            permit_ff <= sfr_wdata[EDA_BIT_PERMIT];
        end
    end

    // software cannot clear it; only a warm reset cuts a write short
    always_ff @(posedge ref_clk) begin
        if (!rst_n || warm_rst) begin
            start_ff <= 1'b0;
        end else if (wr_end) begin
            start_ff <= 1'b0;
        end else if (start_ok) begin
            start_ff <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            abort_ff <= 1'b0;
        end else if (warm_rst) begin
            abort_ff <= abort_ff | start_ff;
        end else if (wr_ctrl) begin
            abort_ff <= sfr_wdata[EDA_BIT_ABORT];
        end
    end

    // completion set wins over a software clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_n || warm_rst) begin
            done_ff <= 1'b0;
        end else if (wr_end) begin
            done_ff <= 1'b1;
        end else if (wr_ctrl) begin
            done_ff <= sfr_wdata[EDA_BIT_DONE];
        end
    end

    // ************************************************************
    // unlock sequence
    // ************************************************************
    // any other bus write between the keys breaks the sequence
    always_ff @(posedge ref_clk) begin
        if (!rst_n || warm_rst) begin
            ul_ff <= EDA_UL_IDLE;
        end else if (sfr_wr) begin
            if (wr_unlock && sfr_wdata == EDA_KEY_FIRST) begin
                ul_ff <= EDA_UL_GOT_FIRST;
            end else if (wr_unlock && sfr_wdata == EDA_KEY_SECOND
                && ul_ff == EDA_UL_GOT_FIRST) begin
                ul_ff <= EDA_UL_ARMED;
            end else begin
                ul_ff <= EDA_UL_IDLE;
            end
        end
    end

    // ************************************************************
    // write timer: erase phase then program phase
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_n || warm_rst) begin
            ws_ff <= EDA_WS_IDLE;
            cnt_ff <= 16'h0000;
        end else begin
            unique case (ws_ff)
                EDA_WS_IDLE: begin
                    if (start_ok) begin
                        ws_ff <= EDA_WS_ERASE;
                        cnt_ff <= 16'(ERASE_CYCLES - 1);
                    end
                end
                EDA_WS_ERASE: begin
                    if (cnt_ff == 16'h0000) begin
                        ws_ff <= EDA_WS_PROG;
                        cnt_ff <= 16'(PROG_CYCLES - 1);
                    end else begin
                        cnt_ff <= cnt_ff - 16'h0001;
                    end
                end
                EDA_WS_PROG: begin
                    if (cnt_ff == 16'h0000) begin
                        ws_ff <= EDA_WS_IDLE;
                    end else begin
                        cnt_ff <= cnt_ff - 16'h0001;
                    end
                end
                default: ws_ff <= EDA_WS_IDLE;
            endcase
        end
    end

    // target latched at start so later register writes do no harm
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wloc_ff <= 6'h00;
            wbyte_ff <= EDA_RST_BYTE;
        end else if (start_ok) begin
            wloc_ff <= addr_ff[5:0];
            wbyte_ff <= addr_hit ? data_ff : EDA_RST_BYTE;
        end
    end

    logic wsel_ff;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wsel_ff <= 1'b0;
        end else if (start_ok) begin
            wsel_ff <= addr_hit;
        end
    end

    // ************************************************************
    // array; nonvolatile, so never reset
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (erase_end && wsel_ff && !warm_rst) begin
            mem[wloc_ff] <= EDA_ERASED;
        end else if (wr_end && wsel_ff) begin
            mem[wloc_ff] <= wbyte_ff;
        end else if (prog_wr_en && !code_protect && ws_ff == EDA_WS_IDLE) begin
            mem[prog_addr] <= prog_wdata;
        end
    end

    // ************************************************************
    // programmer port
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            prog_rdata_ff <= EDA_RST_BYTE;
            prog_denied_ff <= 1'b0;
        end else begin
            prog_denied_ff <= code_protect && (prog_rd_en || prog_wr_en);
            if (prog_rd_en) begin
                prog_rdata_ff <= code_protect ? EDA_RST_BYTE
                    : mem[prog_addr];
            end
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    a_ctrl_upper_zero:
        assert property (sfr_addr == EDA_ADR_CTRL |-> sfr_rdata[7:5] == 3'b000)
        else $error("control upper bits not zero");
    a_unlock_reads_zero:
        assert property (sfr_addr == EDA_ADR_UNLOCK |-> sfr_rdata == 8'h00)
        else $error("unlock register read nonzero");
    a_fetch_one_cycle:
        assert property (fetch_ff |=> !fetch_ff)
        else $error("fetch bit held more than one cycle");
    a_fetch_fills_data:
        assert property (fetch_ff |=> data_ff == $past(rd_word))
        else $error("fetched byte not in data register");
    a_start_needs_key:
        assert property ($rose(start_ff) |->
            $past(ul_ff) == EDA_UL_ARMED && $past(wr_ctrl))
        else $error("write started without unlock sequence");
    a_start_needs_permit:
        assert property (!permit_ff && !start_ff |=> !start_ff)
        else $error("write started while not permitted");
    a_done_at_end:
        assert property (wr_end |=> done_ff && !start_ff
            && ws_ff == EDA_WS_IDLE)
        else $error("completion did not set done flag");
    a_erase_then_prog:
        assert property (erase_end && !warm_rst |=> ws_ff == EDA_WS_PROG
            && (mem[wloc_ff] == EDA_ERASED || !wsel_ff))
        else $error("erase phase not followed by program phase");
    a_abort_sets_flag:
        assert property (warm_rst && start_ff |=> abort_ff && !start_ff)
        else $error("aborted write did not set abort flag");
    a_abort_keeps_regs:
        assert property (warm_rst |=> $stable(addr_ff)
            && (data_ff == $past(data_ff) || $past(fetch_ff)))
        else $error("warm reset disturbed address or data");
    a_protect_denies:
        assert property (code_protect && prog_rd_en |=>
            prog_denied_ff && prog_rdata_ff == EDA_RST_BYTE)
        else $error("programmer read not refused under protection");
    a_permit_blocks_write:
        assert property (ws_ff == EDA_WS_IDLE && !permit_ff |=>
            ws_ff == EDA_WS_IDLE)
        else $error("write cycle began without permit");

endmodule : eda_ctrl

// [pkg/eda_pkg.sv]
// ****************************************************************
// data eeprom access package
// ****************************************************************
package eda_pkg;

    // ************************************************************
    // special function register addresses
    // ************************************************************
    localparam logic [7:0] EDA_ADR_DATA = 8'h08;
    localparam logic [7:0] EDA_ADR_ADDR = 8'h09;
    localparam logic [7:0] EDA_ADR_CTRL = 8'h88;
    localparam logic [7:0] EDA_ADR_UNLOCK = 8'h89;

    // ************************************************************
    // control/status bit positions
    // ************************************************************
    localparam int EDA_BIT_FETCH = 0;
    localparam int EDA_BIT_PROG = 1;
    localparam int EDA_BIT_PERMIT = 2;
    localparam int EDA_BIT_ABORT = 3;
    localparam int EDA_BIT_DONE = 4;

    // ************************************************************
    // unlock key bytes and array geometry
    // ************************************************************
    localparam logic [7:0] EDA_KEY_FIRST = 8'h55;
    localparam logic [7:0] EDA_KEY_SECOND = 8'haa;
    localparam int EDA_DEPTH = 64;
    localparam logic [7:0] EDA_ERASED = 8'hff;

    // ************************************************************
    // reset values and timer defaults (cycles of ref_clk)
    // ************************************************************
    localparam logic [7:0] EDA_RST_BYTE = 8'h00;
    localparam int EDA_ERASE_CYC = 500;
    localparam int EDA_PROG_CYC = 500;

    typedef enum logic [1:0] {
        EDA_UL_IDLE,
        EDA_UL_GOT_FIRST,
        EDA_UL_ARMED
    } eda_unlock_e;

    typedef enum logic [1:0] {
        EDA_WS_IDLE,
        EDA_WS_ERASE,
        EDA_WS_PROG
    } eda_wstate_e;

endpackage : eda_pkg

// [tb/eda_cpu_model.sv]
`timescale 1ns/10ps
// ****
// cpu core stand-in on the sfr port
// ****
module eda_cpu_model
    import eda_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // sfr port
    output logic [7:0] sfr_addr,
    output logic sfr_wr,
    output logic [7:0] sfr_wdata,
    // warm resets
    output logic master_clear_reset,
    output logic watchdog_timeout
);
    initial begin
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_wdata = 8'h00;
        master_clear_reset = 1'b0;
        watchdog_timeout = 1'b0;
    end
    task automatic point(input logic [7:0] a);
        @(posedge ref_clk);
        #1;
        sfr_addr = a;
    endtask : point
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        point(a);
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge ref_clk);
        #1;
        sfr_wr = 1'b0;
        // stale bus never mirrors the last byte
        sfr_wdata = ~d;
    endtask : wr
    task automatic start_write(input logic [7:0] c);
        wr(EDA_ADR_UNLOCK, EDA_KEY_FIRST);
        wr(EDA_ADR_UNLOCK, EDA_KEY_SECOND);
        wr(EDA_ADR_CTRL, c);
    endtask : start_write
    task automatic warm(input int wdt);
        @(posedge ref_clk);
        #1;
        master_clear_reset = (wdt == 0);
        watchdog_timeout = (wdt != 0);
        @(posedge ref_clk);
        #1;
        master_clear_reset = 1'b0;
        watchdog_timeout = 1'b0;
    endtask : warm
endmodule : eda_cpu_model

// [tb/tb_top.sv]
`timescale 1ns/10ps
module tb_top
    import eda_pkg::*;
;
    localparam int CYC = 6;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic code_protect = 1'b0;
    logic prog_rd_en = 1'b0;
    logic prog_wr_en = 1'b0;
    logic [5:0] prog_addr = 6'h00;
    logic [7:0] prog_wdata = 8'h00;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, prog_rdata_ff, a, d;
    logic sfr_wr, master_clear_reset, watchdog_timeout, prog_denied_ff;
    logic chk_req = 1'b0;
    // bit 9 picks the programmer side
    logic [9:0] exp_q [$];
    logic [9:0] e_v, got;
    logic [7:0] mem [64];
    logic [7:0] rst_tbl [5] = '{EDA_ADR_CTRL, EDA_ADR_DATA, EDA_ADR_ADDR,
                                EDA_ADR_UNLOCK, 8'h40};
    int n_mismatch = 0;
    int cmp_count = 0;
    int cyc = 0;
    int t_start = 0;
    always #2 ref_clk = ~ref_clk;
    eda_cpu_model eda_cpu_model_inst (.ref_clk(ref_clk),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
        .master_clear_reset(master_clear_reset),
        .watchdog_timeout(watchdog_timeout));
    eda_ctrl #(.ERASE_CYCLES(CYC), .PROG_CYCLES(CYC)) eda_ctrl_inst (
        .ref_clk(ref_clk), .rst_n(rst_n),
        .master_clear_reset(master_clear_reset),
        .watchdog_timeout(watchdog_timeout), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .code_protect(code_protect), .prog_rd_en(prog_rd_en),
        .prog_wr_en(prog_wr_en), .prog_addr(prog_addr),
        .prog_wdata(prog_wdata), .prog_rdata_ff(prog_rdata_ff),
        .prog_denied_ff(prog_denied_ff));
    // ****
    // result watcher and hang guard
    // ****
    always @(posedge ref_clk) begin
        if (chk_req) begin
            e_v = exp_q.pop_front();
            got = e_v[9] ? {1'b1, prog_denied_ff, prog_rdata_ff}
                         : {2'b00, sfr_rdata};
            cmp_count++;
            if (got !== e_v) begin
                n_mismatch++;
                $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e_v, got);
            end
        end
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run
    // ****
    // bus helpers
    // ****
    task automatic w(input logic [7:0] ad, input logic [7:0] dt);
        eda_cpu_model_inst.wr(ad, dt);
    endtask : w
    task automatic chk(input logic [7:0] ad, input logic [7:0] e);
        eda_cpu_model_inst.point(ad);
        exp_q.push_back({2'b00, e});
        chk_req = 1'b1;
        @(posedge ref_clk);
        #1;
        chk_req = 1'b0;
    endtask : chk
    task automatic start(input logic [7:0] ad, input logic [7:0] dt);
        w(EDA_ADR_ADDR, ad);
        w(EDA_ADR_DATA, dt);
        w(EDA_ADR_CTRL, 8'h04);
        eda_cpu_model_inst.start_write(8'h06);
        t_start = cyc;
        chk(EDA_ADR_CTRL, 8'h06);
    endtask : start
    task automatic wait_idle();
        eda_cpu_model_inst.point(EDA_ADR_CTRL);
        for (int n = 0; n < 40; n++) begin
            @(posedge ref_clk);
            if (sfr_rdata[EDA_BIT_PROG] === 1'b0) break;
        end
        #1;
        cmp_count++;
        // start bit stands erase plus program cycles, seen one edge later
        if (cyc - t_start != 2 * CYC + 1) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time,
                2 * CYC + 1, cyc - t_start);
        end
    endtask : wait_idle
    task automatic ee_write(input logic [7:0] ad, input logic [7:0] dt);
        start(ad, dt);
        wait_idle();
        chk(EDA_ADR_CTRL, 8'h14);
        w(EDA_ADR_CTRL, 8'h04);
        chk(EDA_ADR_CTRL, 8'h04);
        if (ad[7:6] == 2'b00) mem[ad[5:0]] = dt;
    endtask : ee_write
    task automatic ee_read(input logic [7:0] ad, input logic [7:0] e);
        w(EDA_ADR_ADDR, ad);
        w(EDA_ADR_CTRL, 8'h05);
        @(posedge ref_clk);
        chk(EDA_ADR_DATA, e);
        chk(EDA_ADR_CTRL, 8'h04);
    endtask : ee_read
    task automatic prog_rd(input logic [5:0] ad, input logic p,
                           input logic [7:0] e);
        @(posedge ref_clk);
        #1;
        code_protect = p;
        prog_addr = ad;
        prog_wdata = 8'($urandom);
        prog_rd_en = 1'b1;
        // a write rides along: refused when protected, lands otherwise
        prog_wr_en = 1'b1;
        @(posedge ref_clk);
        #1;
        prog_rd_en = 1'b0;
        prog_wr_en = 1'b0;
        exp_q.push_back({1'b1, p, e});
        if (!p) mem[ad] = prog_wdata;
        chk_req = 1'b1;
        @(posedge ref_clk);
        #1;
        chk_req = 1'b0;
    endtask : prog_rd
    // ****
    // test sequence
    // ****
    initial begin
        void'($urandom(32'ha2de));
        repeat (10) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        foreach (rst_tbl[i]) chk(rst_tbl[i], 8'h00);
        w(EDA_ADR_CTRL, 8'he4);
        chk(EDA_ADR_CTRL, 8'h04);
        w(EDA_ADR_UNLOCK, 8'h5a);
        chk(EDA_ADR_UNLOCK, 8'h00);
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            a = (i == 0) ? 8'h3f : (i == 1) ? 8'h00 : (i == 2) ? 8'h05
                : (8'($urandom) & 8'h3f);
            ee_write(a, 8'($urandom));
            ee_read(a, mem[a[5:0]]);
        end
        $display("test write read done");
        w(EDA_ADR_CTRL, 8'h06);
        chk(EDA_ADR_CTRL, 8'h04);
        w(EDA_ADR_UNLOCK, EDA_KEY_FIRST);
        w(EDA_ADR_ADDR, 8'h00);
        w(EDA_ADR_UNLOCK, EDA_KEY_SECOND);
        w(EDA_ADR_CTRL, 8'h06);
        chk(EDA_ADR_CTRL, 8'h04);
        w(EDA_ADR_CTRL, 8'h00);
        eda_cpu_model_inst.start_write(8'h02);
        chk(EDA_ADR_CTRL, 8'h00);
        ee_read(8'h00, mem[0]);
        d = 8'($urandom);
        start(8'h00, d);
        w(EDA_ADR_CTRL, 8'h00);
        chk(EDA_ADR_CTRL, 8'h02);
        wait_idle();
        chk(EDA_ADR_CTRL, 8'h10);
        mem[0] = d;
        ee_read(8'h00, d);
        $display("test refusals done");
        for (int i = 0; i < 2; i++) begin
            a = 8'($urandom) & 8'h3f;
            d = 8'($urandom);
            start(a, d);
            eda_cpu_model_inst.warm(i);
            chk(EDA_ADR_CTRL, 8'h08);
            chk(EDA_ADR_ADDR, a);
            chk(EDA_ADR_DATA, d);
            ee_write(a, d);
            ee_read(a, d);
        end
        $display("test aborts done");
        ee_write(8'h45, 8'($urandom));
        ee_read(8'h45, 8'h00);
        ee_read(8'h05, mem[5]);
        $display("test upper address done");
        prog_rd(6'h3f, 1'b1, 8'h00);
        ee_read(8'h3f, mem[63]);
        ee_write(8'h3f, 8'($urandom));
        ee_read(8'h3f, mem[63]);
        prog_rd(6'h3f, 1'b0, mem[63]);
        ee_read(8'h3f, mem[63]);
        $display("test protection done");
        complete_run();
    end
endmodule : tb_top
